/* bench/agrc_config_checker.sv */
// port-level assertions for the configuration bank
`timescale 1ns/1ps
module agrc_config_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] amp_enable_field_ff,
   input wire logic amp_bypass_ff,
   input wire logic [7:0] amp_gain_ff,
   input wire logic [3:0] output_rate_code_ff,
   input wire logic rate_reserved_ff,
   input wire logic [1:0] scale_monitor_enable_ff,
   input wire logic mon_high_en_ff,
   input wire logic mon_pull_en_ff,
   input wire logic [1:0] scale_input_select_ff,
   input wire logic sel_internal_ff,
   input wire logic [1:0] internal_scale_config_ff,
   input wire logic int_src_on_ff,
   input wire logic conv_start_ff
);
default clocking cb @(posedge clk); endclocking
default disable iff (!resetn);
////////////////////////////////////////////////////////////////////////////
a_ready_after_setup:
   assert property (psel && !penable |=> pready) else $error("pready late");
a_ready_one_cycle:
   assert property (pready |=> !pready) else $error("pready too long");
a_err_with_ready:
   assert property (pslverr |-> pready) else $error("pslverr alone");
a_gain_update:
   assert property (psel && penable && pready && pwrite && !pslverr &&
      pstrb[0] && paddr == 32'h0000000C |=> ##1
      amp_gain_ff == (8'h01 << $past(pwdata[2:0], 2)))
      else $error("gain decode wrong");
a_bypass_decode:
   assert property (amp_bypass_ff == (amp_enable_field_ff != 3'h1))
      else $error("bypass decode wrong");
a_rate_reserved:
   assert property (rate_reserved_ff == (output_rate_code_ff > 4'hB))
      else $error("rate reserved wrong");
a_monitor_decode:
   assert property (mon_high_en_ff == (scale_monitor_enable_ff == 2'h2) &&
      mon_pull_en_ff == (scale_monitor_enable_ff == 2'h3))
      else $error("monitor decode wrong");
a_select_decode:
   assert property (sel_internal_ff == (scale_input_select_ff == 2'h2))
      else $error("select decode wrong");
a_source_decode:
   assert property (int_src_on_ff == (internal_scale_config_ff == 2'h1 ||
      internal_scale_config_ff == 2'h2)) else $error("source decode wrong");
a_start_single:
   assert property (conv_start_ff |=> !conv_start_ff)
      else $error("start pulse too long");
c_write: cover property (psel && penable && pready && pwrite);
c_error: cover property (pslverr);
c_start: cover property (conv_start_ff);
endmodule
bind agrc_config_regs agrc_config_checker u_chk (.*);

/* bench/agrc_config_regs_tb.sv */
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`include "agrc_map.vh"
module agrc_config_regs_tb;
logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, prdata;
logic [3:0] pstrb = 4'hF;
logic pready, pslverr, amp_bypass_ff, chop_en_ff, ext_clk_sel_ff, err;
logic single_shot_ff, low_latency_ff, rate_reserved_ff, mon_low_en_ff;
logic mon_high_en_ff, mon_pull_en_ff, pos_scale_buffer_en_ff;
logic neg_scale_buffer_en_ff, sel_internal_ff, int_src_on_ff;
logic int_src_keep_ff, conv_start_ff, delay_busy_ff;
logic [2:0] amp_enable_field_ff;
logic [7:0] amp_gain_ff, v;
logic [3:0] output_rate_code_ff;
logic [10:0] rate_sps_x2_ff;
logic [1:0] scale_monitor_enable_ff, scale_input_select_ff;
logic [1:0] internal_scale_config_ff;
int miscompares = 0, tests_run = 0, n;
localparam int X2 [12] = '{5,10,20,33,40,100,120,200,400,800,1600,2000};
localparam int DL [8] = '{14, 25, 64, 256, 1024, 2048, 4096, 4096};
agrc_config_regs DUT (.*);
always #25 clk = ~clk;
////////////////////////////////////////////////////////////////////////////
task chk(input string nm, input logic [31:0] e, g);
   tests_run++;
   if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
   end
endtask
task apb(input logic w, input logic [31:0] a, d);
   @(posedge clk);
   psel <= 1'b1;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge clk);
   penable <= 1'b1;
   n = 0;
   do begin
      @(posedge clk);
      n++;
   end while (pready !== 1'b1 && n < 20);
   chk("pready", 1'b1, pready);
   rd = prdata;
   err = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
endtask
task wr(input logic [31:0] a, d);
   apb(1'b1, a, d);
   repeat (2) @(posedge clk);
endtask
task rdc(input string nm, input logic [31:0] a, e);
   apb(1'b0, a, 32'h0);
   chk(nm, e, rd);
endtask
////////////////////////////////////////////////////////////////////////////
task t_reset;
   rdc("gain reg", 32'h0C, 32'h00);
   rdc("rate reg", 32'h10, 32'h14);
   rdc("scale reg", 32'h14, 32'h10);
   chk("bypass", 1'b1, amp_bypass_ff);
   chk("gain", 8'h01, amp_gain_ff);
   chk("low latency", 1'b1, low_latency_ff);
   chk("rate x2", 10'h28, rate_sps_x2_ff);
   chk("pos buf", 1'b1, pos_scale_buffer_en_ff);
   chk("neg buf", 1'b0, neg_scale_buffer_en_ff);
endtask
task t_gain;
   for (int i = 0; i < 32; i++) begin
      v = {3'h0, i[4:3], i[4:3] == 2'h1 ? i[2:0] : 3'h0};
      wr(32'h0C, v);
      chk("gain", 8'h01 << v[2:0], amp_gain_ff);
      chk("amp field", v[4:3], amp_enable_field_ff);
      chk("bypass", v[4:3] != 2'h1, amp_bypass_ff);
      rdc("gain back", 32'h0C, v);
   end
endtask
task t_rate;
   for (int i = 0; i < 16; i++) begin
      v = {i[3:0] ^ 4'h5, i[3:0]};
      wr(32'h10, v);
      chk("chop", v[7], chop_en_ff);
      chk("ext clock", v[6], ext_clk_sel_ff);
      chk("single", v[5], single_shot_ff);
      chk("low latency", v[4], low_latency_ff);
      chk("rate code", v[3:0], output_rate_code_ff);
      chk("reserved", i > 11, rate_reserved_ff);
      chk("rate x2", i > 11 ? 0 : X2[i], rate_sps_x2_ff);
      rdc("rate back", 32'h10, v);
   end
endtask
task t_scale;
   for (int i = 0; i < 4; i++) begin
      v = {i[1:0], i[0], i[1], i[1:0], i[1:0]};
      wr(32'h14, v);
      chk("monitor", v[7:6], scale_monitor_enable_ff);
      chk("mon low", v[7:6] != 2'h0, mon_low_en_ff);
      chk("mon high", v[7:6] == 2'h2, mon_high_en_ff);
      chk("mon pull", v[7:6] == 2'h3, mon_pull_en_ff);
      chk("pos buf", !v[5], pos_scale_buffer_en_ff);
      chk("neg buf", !v[4], neg_scale_buffer_en_ff);
      chk("select", v[3:2], scale_input_select_ff);
      chk("internal", v[3:2] == 2'h2, sel_internal_ff);
      chk("src on", v[1:0] == 2'h1 || v[1:0] == 2'h2, int_src_on_ff);
      chk("src keep", v[1:0] == 2'h2, int_src_keep_ff);
      rdc("scale back", 32'h14, v);
   end
endtask
task t_err;
   wr(32'h0C, 32'h09);
   apb(1'b1, 32'h00, 32'hFF);
   chk("error low", 1'b1, err);
   apb(1'b1, 32'h0D, 32'hFF);
   chk("error odd", 1'b1, err);
   apb(1'b0, 32'h40, 32'h0);
   chk("error far", 1'b1, err);
   chk("error data", 32'h0, rd);
   pstrb <= 4'h0;
   apb(1'b1, 32'h0C, 32'hFF);
   pstrb <= 4'hF;
   rdc("gain kept", 32'h0C, 32'h09);
endtask
task t_delay;
   int d;
   for (int k = 0; k < 9; k++) begin
      d = k < 8 ? 7 - k : 0;
      if (k < 8) apb(1'b1, 32'h0C, {d[2:0], 5'h08});
      else apb(1'b1, 32'h18, 32'h01);
      rdc("status busy", 32'h1C, 32'h03);
      n = 0;
      while (conv_start_ff !== 1'b1 && n < 30000) begin
         @(posedge clk);
         n++;
      end
      v = DL[d] * `AGRC_MOD_DIV <= n && n <= DL[d] * `AGRC_MOD_DIV + 8;
      chk("delay", 8'h01, v);
      n = 0;
      repeat (300) begin
         @(posedge clk);
         if (conv_start_ff === 1'b1) n++;
      end
      chk("one start", 32'h0, n);
      rdc("status idle", 32'h1C, 32'h00);
   end
endtask
task end_of_test;
   $display("checks %0d mismatches %0d", tests_run, miscompares);
   if (miscompares == 0 && tests_run > 0) $display("All tests passed");
   else $display("Some tests failed");
   $finish;
endtask
initial begin
   repeat (4) @(posedge clk);
   resetn <= 1'b1;
   repeat (3) @(posedge clk);
   t_reset;
   t_gain;
   t_rate;
   t_scale;
   t_err;
   t_delay;
   end_of_test;
end
initial begin
   #(50 * 90000);
   miscompares++;
   end_of_test;
end
endmodule

/* hw/agrc_config_regs.v */
// configuration register bank for gain, output rate and scale control
`timescale 1ns/1ps
`include "agrc_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// - gain register at 03h, resets 00h
// - delay field decodes to modulator period counts
// - delay only before first conversion after write
// - amplifier enable: 00 bypass, 01 on
// - gain field is power of two
// - rate register at 04h, resets 14h
// - chop bit swaps inputs, averages pairs
// - clock source bit: internal or external
// - mode bit: continuous or single shot
// - filter bit: sinc3 or low latency
// - rate field decodes twelve rates
// - scale register at 05h, resets 10h
// - scale register field layout
// - monitor enable field decode
// - scale input select decode
// - internal source configuration decode
// - positive buffer bypass disables buffer
module agrc_config_regs (
   input wire clk,
   input wire resetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg [2:0] amp_enable_field_ff,
   output reg amp_bypass_ff,
   output reg [7:0] amp_gain_ff,
   output reg chop_en_ff,
   output reg ext_clk_sel_ff,
   output reg single_shot_ff,
   output reg low_latency_ff,
   output reg [3:0] output_rate_code_ff,
   output reg [10:0] rate_sps_x2_ff,
   output reg rate_reserved_ff,
   output reg [1:0] scale_monitor_enable_ff,
   output reg mon_low_en_ff,
   output reg mon_high_en_ff,
   output reg mon_pull_en_ff,
   output reg pos_scale_buffer_en_ff,
   output reg neg_scale_buffer_en_ff,
   output reg [1:0] scale_input_select_ff,
   output reg sel_internal_ff,
   output reg [1:0] internal_scale_config_ff,
   output reg int_src_on_ff,
   output reg int_src_keep_ff,
   output reg conv_start_ff,
   output reg delay_busy_ff
);
   reg rs1_ff;
   reg rst_n;
   reg [7:0] gain_reg_ff;
   reg [7:0] rate_reg_ff;
   reg [7:0] scale_reg_ff;
   reg restart_ff;
   reg first_pending_ff;
   wire [12:0] dly_periods;
   wire [2:0] dly_code;
   wire [1:0] amp_field;
   wire [2:0] gain_code;
   wire [3:0] rate_code;
   wire [1:0] mon_field;
   wire [1:0] sel_field;
   wire [1:0] con_field;
   wire chop_bit;
   wire clk_src_bit;
   wire mode_bit;
   wire filt_bit;
   wire pbyp_bit;
   wire nbyp_bit;
   wire mod_tick;
   wire dly_busy;
   wire dly_done;
   wire wr_acc;
   wire rd_acc;
   wire [7:0] wbyte;
   reg [7:0] nxt_rdata;
   reg nxt_err;

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flip-flops
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rs1_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_ff <= 1'b1;
         rst_n <= rs1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode functions
   function [12:0] delay_periods;
      input [2:0] code;
      begin
         case (code)
            3'h0: delay_periods = `AGRC_DLY_C0;
            3'h1: delay_periods = `AGRC_DLY_C1;
            3'h2: delay_periods = `AGRC_DLY_C2;
            3'h3: delay_periods = `AGRC_DLY_C3;
            3'h4: delay_periods = `AGRC_DLY_C4;
            3'h5: delay_periods = `AGRC_DLY_C5;
            default: delay_periods = `AGRC_DLY_C6;
         endcase
      end
   endfunction

   function [10:0] rate_x2;
      input [3:0] code;
      begin
         case (code)
            4'h0: rate_x2 = `AGRC_X2_0;
            4'h1: rate_x2 = `AGRC_X2_1;
            4'h2: rate_x2 = `AGRC_X2_2;
            4'h3: rate_x2 = `AGRC_X2_3;
            4'h4: rate_x2 = `AGRC_X2_4;
            4'h5: rate_x2 = `AGRC_X2_5;
            4'h6: rate_x2 = `AGRC_X2_6;
            4'h7: rate_x2 = `AGRC_X2_7;
            4'h8: rate_x2 = `AGRC_X2_8;
            4'h9: rate_x2 = `AGRC_X2_9;
            4'hA: rate_x2 = `AGRC_X2_A;
            4'hB: rate_x2 = `AGRC_X2_B;
            default: rate_x2 = 11'h000;
         endcase
      end
   endfunction

   function [7:0] merge_byte;
      input [7:0] old;
      input [7:0] val;
      input en;
      begin
         merge_byte = en ? val : old;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;
   assign wbyte = pwdata[7:0];

   always @* begin
      nxt_rdata = 8'h00;
      nxt_err = 1'b0;
      case (paddr[9:2])
         `AGRC_OFF_GAIN: nxt_rdata = gain_reg_ff;
         `AGRC_OFF_RATE: nxt_rdata = rate_reg_ff;
         `AGRC_OFF_SCALE: nxt_rdata = scale_reg_ff;
         `AGRC_OFF_CTRL: nxt_rdata = 8'h00;
         `AGRC_OFF_STAT: nxt_rdata = {6'h00, first_pending_ff, dly_busy};
         default: nxt_err = 1'b1;
      endcase
      if (paddr[1:0] != 2'b00 || paddr[31:10] != 22'h000000) begin
         nxt_err = 1'b1;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && nxt_err;
         if (rd_acc) begin
            prdata <= {24'h000000, nxt_rdata};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register storage
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_reg_ff <= `AGRC_RST_GAIN;
         rate_reg_ff <= `AGRC_RST_RATE;
         scale_reg_ff <= `AGRC_RST_SCALE;
         restart_ff <= 1'b0;
      end else begin
         restart_ff <= 1'b0;
         if (wr_acc && pready && !pslverr) begin
            case (paddr[9:2])
               `AGRC_OFF_GAIN: begin
                  gain_reg_ff <= merge_byte(gain_reg_ff, wbyte, pstrb[0]);
                  restart_ff <= pstrb[0];
               end
               `AGRC_OFF_RATE: begin
                  rate_reg_ff <= merge_byte(rate_reg_ff, wbyte, pstrb[0]);
                  restart_ff <= pstrb[0];
               end
               `AGRC_OFF_SCALE: begin
                  scale_reg_ff <= merge_byte(scale_reg_ff, wbyte, pstrb[0]);
                  restart_ff <= pstrb[0];
               end
               `AGRC_OFF_CTRL: begin
                  restart_ff <= pstrb[0] & wbyte[0];
               end
               default: begin
                  restart_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // first-conversion delay
   agrc_tick_div #(
      .DIV(`AGRC_MOD_DIV)
   ) u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .tick_ff(mod_tick)
   );

   assign dly_periods = delay_periods(dly_code);

   agrc_delay_counter #(
      .CW(13)
   ) u_delay (
      .clk(clk),
      .rst_n(rst_n),
      .mod_tick(mod_tick),
      .start(restart_ff),
      .periods(dly_periods),
      .busy_ff(dly_busy),
      .done_ff(dly_done)
   );

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_pending_ff <= 1'b0;
         conv_start_ff <= 1'b0;
         delay_busy_ff <= 1'b0;
      end else begin
         delay_busy_ff <= dly_busy;
         conv_start_ff <= dly_done;
         if (restart_ff) begin
            first_pending_ff <= 1'b1;
         end else if (dly_done) begin
            first_pending_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field extraction
   assign dly_code = gain_reg_ff[`AGRC_DLY_HI:`AGRC_DLY_LO];
   assign amp_field = gain_reg_ff[`AGRC_AMP_HI:`AGRC_AMP_LO];
   assign gain_code = gain_reg_ff[`AGRC_GAIN_HI:`AGRC_GAIN_LO];
   assign rate_code = rate_reg_ff[`AGRC_RATE_HI:`AGRC_RATE_LO];
   assign chop_bit = rate_reg_ff[`AGRC_CHOP_BIT];
   assign clk_src_bit = rate_reg_ff[`AGRC_CLK_BIT];
   assign mode_bit = rate_reg_ff[`AGRC_MODE_BIT];
   assign filt_bit = rate_reg_ff[`AGRC_FILT_BIT];
   assign mon_field = scale_reg_ff[`AGRC_MON_HI:`AGRC_MON_LO];
   assign pbyp_bit = scale_reg_ff[`AGRC_PBYP_BIT];
   assign nbyp_bit = scale_reg_ff[`AGRC_NBYP_BIT];
   assign sel_field = scale_reg_ff[`AGRC_SEL_HI:`AGRC_SEL_LO];
   assign con_field = scale_reg_ff[`AGRC_CON_HI:`AGRC_CON_LO];

   ////////////////////////////////////////////////////////////////////////////
   // gain register decode
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         amp_enable_field_ff <= 3'h0;
         amp_bypass_ff <= 1'b1;
         amp_gain_ff <= 8'h01;
      end else begin
         amp_enable_field_ff <= {1'b0, amp_field};
         amp_bypass_ff <= amp_field != 2'h1;
         amp_gain_ff <= 8'h01 << gain_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // rate register decode
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chop_en_ff <= 1'b0;
         ext_clk_sel_ff <= 1'b0;
         single_shot_ff <= 1'b0;
         low_latency_ff <= 1'b1;
         output_rate_code_ff <= 4'h4;
         rate_sps_x2_ff <= 11'h028;
         rate_reserved_ff <= 1'b0;
      end else begin
         chop_en_ff <= chop_bit;
         ext_clk_sel_ff <= clk_src_bit;
         single_shot_ff <= mode_bit;
         low_latency_ff <= filt_bit;
         output_rate_code_ff <= rate_code;
         rate_sps_x2_ff <= rate_x2(rate_code);
         rate_reserved_ff <= rate_code > `AGRC_RATE_MAX;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scale register decode
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scale_monitor_enable_ff <= 2'h0;
         mon_low_en_ff <= 1'b0;
         mon_high_en_ff <= 1'b0;
         mon_pull_en_ff <= 1'b0;
         pos_scale_buffer_en_ff <= 1'b1;
         neg_scale_buffer_en_ff <= 1'b0;
         scale_input_select_ff <= 2'h0;
         sel_internal_ff <= 1'b0;
         internal_scale_config_ff <= 2'h0;
         int_src_on_ff <= 1'b0;
         int_src_keep_ff <= 1'b0;
      end else begin
         scale_monitor_enable_ff <= mon_field;
         mon_low_en_ff <= mon_field != 2'h0;
         mon_high_en_ff <= mon_field == 2'h2;
         mon_pull_en_ff <= mon_field == 2'h3;
         pos_scale_buffer_en_ff <= !pbyp_bit;
         neg_scale_buffer_en_ff <= !nbyp_bit;
         scale_input_select_ff <= sel_field;
         sel_internal_ff <= sel_field == 2'h2;
         internal_scale_config_ff <= con_field;
         int_src_on_ff <= (con_field == 2'h1) || (con_field == 2'h2);
         int_src_keep_ff <= con_field == 2'h2;
      end
   end
endmodule

/* hw/agrc_delay_counter.v */
// counts modulator periods for the first-conversion delay
`timescale 1ns/1ps
module agrc_delay_counter #(
   parameter CW = 13
) (
   input wire clk,
   input wire rst_n,
   input wire mod_tick,
   input wire start,
   input wire [CW-1:0] periods,
   output reg busy_ff,
   output reg done_ff
);
   reg [CW-1:0] cnt_ff;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= {CW{1'b0}};
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (start) begin
            cnt_ff <= periods;
            busy_ff <= 1'b1;
         end else if (busy_ff && mod_tick) begin
            // extra tick covers the partial first period
            if (cnt_ff == {CW{1'b0}}) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

/* hw/agrc_map.vh */
// register offsets, reset values, field positions and timing constants
`ifndef AGRC_MAP_VH
`define AGRC_MAP_VH
`define AGRC_OFF_GAIN 8'h03
`define AGRC_OFF_RATE 8'h04
`define AGRC_OFF_SCALE 8'h05
`define AGRC_OFF_CTRL 8'h06
`define AGRC_OFF_STAT 8'h07
`define AGRC_RST_GAIN 8'h00
`define AGRC_RST_RATE 8'h14
`define AGRC_RST_SCALE 8'h10
`define AGRC_DLY_HI 7
`define AGRC_DLY_LO 5
`define AGRC_AMP_HI 4
`define AGRC_AMP_LO 3
`define AGRC_GAIN_HI 2
`define AGRC_GAIN_LO 0
`define AGRC_CHOP_BIT 7
`define AGRC_CLK_BIT 6
`define AGRC_MODE_BIT 5
`define AGRC_FILT_BIT 4
`define AGRC_RATE_HI 3
`define AGRC_RATE_LO 0
`define AGRC_MON_HI 7
`define AGRC_MON_LO 6
`define AGRC_PBYP_BIT 5
`define AGRC_NBYP_BIT 4
`define AGRC_SEL_HI 3
`define AGRC_SEL_LO 2
`define AGRC_CON_HI 1
`define AGRC_CON_LO 0
`define AGRC_MOD_DIV 5
`define AGRC_RATE_MAX 4'hB
`define AGRC_DLY_C0 13'h000E
`define AGRC_DLY_C1 13'h0019
`define AGRC_DLY_C2 13'h0040
`define AGRC_DLY_C3 13'h0100
`define AGRC_DLY_C4 13'h0400
`define AGRC_DLY_C5 13'h0800
`define AGRC_DLY_C6 13'h1000
`define AGRC_X2_0 11'h005
`define AGRC_X2_1 11'h00A
`define AGRC_X2_2 11'h014
`define AGRC_X2_3 11'h021
`define AGRC_X2_4 11'h028
`define AGRC_X2_5 11'h064
`define AGRC_X2_6 11'h078
`define AGRC_X2_7 11'h0C8
`define AGRC_X2_8 11'h190
`define AGRC_X2_9 11'h320
`define AGRC_X2_A 11'h640
`define AGRC_X2_B 11'h7D0
`endif

/* hw/agrc_tick_div.v */
// divider making the one-cycle modulator period enable
`timescale 1ns/1ps
module agrc_tick_div #(
   parameter DIV = 5
) (
   input wire clk,
   input wire rst_n,
   output reg tick_ff
);
   reg [7:0] cnt_ff;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 8'h00;
         tick_ff <= 1'b0;
      end else if (cnt_ff == DIV[7:0] - 8'h01) begin
         cnt_ff <= 8'h00;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
         tick_ff <= 1'b0;
      end
   end
endmodule
